//--- design/rtx_ctrl_bank.sv
// Retimer transmit, equalizer and lane verifier control register bank
//
// Operation
// RULE_01 - Termination code 00 none, 01 150-300 ohm; writes ignored in strap mode
// RULE_02 - Tap weight is signed: 00 none, 01 2 dB, other codes reserved
// RULE_03 - Tap weight mirrors the strap pin; writes dropped in strap mode
// RULE_04 - One bit sets both display channel bridges: 0 slow, 1 fast
// RULE_05 - Host sets hotplug sleep disable before choosing the fast speed
// RULE_06 - Data swing: 000 resistor level, then three raises, four cuts
// RULE_07 - Clock swing: 000 follows data rate, others override by percent
// RULE_08 - Data lane equalizer 0 to 16.5 dB; clock lane 0, 1.5, 3 dB
// RULE_09 - Per-lane load bit passes settings through, held when it falls
// RULE_10 - Per-lane sync bit marks each full pattern generator cycle
// RULE_11 - Upper status nibble reports per-lane mismatch, hardware driven only
// RULE_12 - Lower status nibble high while lane searches or trains
// RULE_13 - Long mode bit picks 16-bit pattern at 0, 20-bit at 1
// RULE_14 - Select decodes off, PRBS, clock, custom, timing; lengths pair up
// RULE_15 - Lane analog settings change only when apply is pulsed
// RULE_16 - Reserved bits read reset values and ignore writes
module rtx_ctrl_bank (
  // Clock and reset
  input  wire logic                     MCLK_IN,
  input  wire logic                     RESETN_IN,
  // Register port
  input  wire logic [7:0]               REG_ADDR_IN,
  input  wire logic                     REG_WR_IN,
  input  wire logic [7:0]               REG_WDATA_IN,
  output logic [7:0]                    REG_RDATA_OUT,
  // Strap pins and apply strobe
  input  wire logic                     PIN_STRAP_MODE_IN,
  input  wire logic                     PRE_EMPH_STRAP_IN,
  input  wire logic                     APPLY_LANE_SETTINGS_IN,
  // Verifier inputs from outside this bank
  input  wire logic [rtx_pkg::TIMEOUT_W-1:0] VERIFIER_TIMEOUT_IN,
  input  wire logic [3:0]               CUSTOM_PATTERN_TOP_IN,
  input  wire logic [rtx_pkg::LANES-1:0] LANE_SYNC_IN,
  input  wire logic [rtx_pkg::LANES-1:0] LANE_MISMATCH_IN,
  input  wire logic [rtx_pkg::LANES-1:0] LANE_TRAINING_IN,
  // Applied lane analog settings, and the channel speed that needs no apply
  output logic [1:0]                    TX_TERMINATION_OUT,
  output logic [1:0]                    TAP_WEIGHT_OUT,
  output logic [2:0]                    DATA_SWING_OUT,
  output logic [2:0]                    CLOCK_SWING_OUT,
  output logic [2:0]                    DATA_EQ_OUT,
  output logic [1:0]                    CLOCK_EQ_OUT,
  output logic                          DDC_FAST_MODE_OUT,
  // Held verifier settings per lane
  output logic [rtx_pkg::LANES-1:0][2:0] LANE_PATTERN_MODE_OUT,
  output logic [rtx_pkg::LANES-1:0][2:0] LANE_PRBS_LENGTH_OUT,
  output logic [rtx_pkg::LANES-1:0]     LANE_LONG_MODE_OUT,
  output logic [rtx_pkg::LANES-1:0][rtx_pkg::CP_W-1:0] LANE_PATTERN_OUT,
  output logic [rtx_pkg::LANES-1:0][rtx_pkg::TIMEOUT_W-1:0] LANE_TIMEOUT_OUT
);
  import rtx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [1:0]       transmit_termination_select;
  logic             display_channel_speed_select;
  logic [2:0]       data_output_swing_select;
  logic [2:0]       clock_output_swing_select;
  logic [1:0]       post_cursor_tap_weight;
  logic [2:0]       data_eq_select;
  logic [1:0]       clock_eq_select;
  logic [LANES-1:0] verifier_lane_load;
  logic [LANES-1:0] verifier_sync_pulse;
  logic [LANES-1:0] lane_mismatch;
  logic [LANES-1:0] lane_training;
  logic             custom_pattern_long_mode;
  logic [2:0]       verifier_prbs_length;
  logic [2:0]       verifier_pattern_select;
  logic [7:0]       custom_pattern_low;
  logic [7:0]       custom_pattern_mid;
  logic [LANES-1:0] next_sync;

  // Write strobe for one offset
  function automatic logic wr_hit(input logic       wr,
                                  input logic [7:0] addr,
                                  input logic [7:0] target);
    return wr && (addr == target);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Termination and display channel speed
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      transmit_termination_select  <= RST_ZERO[TERM_LSB +: 2];
      display_channel_speed_select <= RST_ZERO[DDC_BIT];
    end else if (wr_hit(REG_WR_IN, REG_ADDR_IN, ADDR_TERM_DDC)) begin
      display_channel_speed_select <= REG_WDATA_IN[DDC_BIT]; // RULE_04
      if (!PIN_STRAP_MODE_IN) begin
        transmit_termination_select <= REG_WDATA_IN[TERM_LSB +: 2]; // RULE_01
      end
    end
  end

  // Output swing fields
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      data_output_swing_select  <= RST_ZERO[DSWING_LSB +: 3];
      clock_output_swing_select <= RST_ZERO[CSWING_LSB +: 3];
    end else if (wr_hit(REG_WR_IN, REG_ADDR_IN, ADDR_SWING_TAP)) begin
      data_output_swing_select  <= REG_WDATA_IN[DSWING_LSB +: 3]; // RULE_06
      clock_output_swing_select <= REG_WDATA_IN[CSWING_LSB +: 3]; // RULE_07
    end
  end

  // Tap weight, taken from the strap pin in strap mode
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      post_cursor_tap_weight <= RST_ZERO[TAP_LSB +: 2];
    end else if (PIN_STRAP_MODE_IN) begin
      post_cursor_tap_weight <= PRE_EMPH_STRAP_IN ? TAP_2DB : TAP_NONE; // RULE_03
    end else if (wr_hit(REG_WR_IN, REG_ADDR_IN, ADDR_SWING_TAP)) begin
      post_cursor_tap_weight <= REG_WDATA_IN[TAP_LSB +: 2];
    end
  end

  // Fixed equalizer gain codes
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      data_eq_select  <= RST_EQ_GAIN[DEQ_LSB +: 3];
      clock_eq_select <= RST_EQ_GAIN[CEQ_LSB +: 2];
    end else if (wr_hit(REG_WR_IN, REG_ADDR_IN, ADDR_EQ_GAIN)) begin
      data_eq_select  <= REG_WDATA_IN[DEQ_LSB +: 3]; // RULE_08
      clock_eq_select <= REG_WDATA_IN[CEQ_LSB +: 2]; // RULE_08
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lane load bits
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      verifier_lane_load <= RST_ZERO[LOAD_LSB +: LANES];
    end else if (wr_hit(REG_WR_IN, REG_ADDR_IN, ADDR_LOAD_SYNC)) begin
      verifier_lane_load <= REG_WDATA_IN[LOAD_LSB +: LANES]; // RULE_09
    end
  end

  // Sync bits: a lane pulse sets, a write may clear, the pulse wins
  always_comb begin
    next_sync = verifier_sync_pulse;
    if (wr_hit(REG_WR_IN, REG_ADDR_IN, ADDR_LOAD_SYNC)) begin
      next_sync = REG_WDATA_IN[SYNC_LSB +: LANES];
    end
    next_sync = next_sync | LANE_SYNC_IN; // RULE_10
  end

  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      verifier_sync_pulse <= RST_ZERO[SYNC_LSB +: LANES];
    end else begin
      verifier_sync_pulse <= next_sync;
    end
  end

  // Lane status, hardware driven, software writes have no path here
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      lane_mismatch <= RST_ZERO[SYNC_LSB +: LANES];
      lane_training <= RST_ZERO[LOAD_LSB +: LANES];
    end else begin
      lane_mismatch <= LANE_MISMATCH_IN; // RULE_11
      lane_training <= LANE_TRAINING_IN; // RULE_12
    end
  end

  // Pattern configuration
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      custom_pattern_long_mode <= RST_ZERO[CP20_BIT];
      verifier_prbs_length     <= RST_ZERO[LEN_LSB +: 3];
      verifier_pattern_select  <= RST_ZERO[SEL_LSB +: 3];
    end else if (wr_hit(REG_WR_IN, REG_ADDR_IN, ADDR_PAT_CFG)) begin
      custom_pattern_long_mode <= REG_WDATA_IN[CP20_BIT]; // RULE_13
      verifier_prbs_length     <= REG_WDATA_IN[LEN_LSB +: 3];
      verifier_pattern_select  <= REG_WDATA_IN[SEL_LSB +: 3];
    end
  end

  // Custom pattern bytes
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      custom_pattern_low <= RST_ZERO;
      custom_pattern_mid <= RST_ZERO;
    end else begin
      if (wr_hit(REG_WR_IN, REG_ADDR_IN, ADDR_CP_LOW)) begin
        custom_pattern_low <= REG_WDATA_IN;
      end
      if (wr_hit(REG_WR_IN, REG_ADDR_IN, ADDR_CP_MID)) begin
        custom_pattern_mid <= REG_WDATA_IN;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Applied analog settings, reserved codes fall back to the safe code
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      TX_TERMINATION_OUT <= TERM_NONE;
      TAP_WEIGHT_OUT     <= TAP_NONE;
      DATA_SWING_OUT     <= SWING_DEF;
      CLOCK_SWING_OUT    <= SWING_DEF;
      DATA_EQ_OUT        <= RST_EQ_GAIN[DEQ_LSB +: 3];
      CLOCK_EQ_OUT       <= RST_EQ_GAIN[CEQ_LSB +: 2];
    end else if (APPLY_LANE_SETTINGS_IN) begin // RULE_15
      TX_TERMINATION_OUT <= (transmit_termination_select == TERM_150) // RULE_01
                            ? TERM_150 : TERM_NONE;
      TAP_WEIGHT_OUT     <= (post_cursor_tap_weight == TAP_2DB) // RULE_02
                            ? TAP_2DB : TAP_NONE;
      DATA_SWING_OUT     <= data_output_swing_select; // RULE_06
      CLOCK_SWING_OUT    <= clock_output_swing_select; // RULE_07
      DATA_EQ_OUT        <= data_eq_select;
      CLOCK_EQ_OUT       <= (clock_eq_select == CEQ_RSVD) // RULE_08
                            ? CEQ_0DB : clock_eq_select;
    end
  end

  // Channel speed acts at once
  assign DDC_FAST_MODE_OUT = display_channel_speed_select; // RULE_04

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the address; unmapped offsets read zero
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      REG_RDATA_OUT <= RST_ZERO;
    end else begin
      REG_RDATA_OUT <= RST_ZERO; // RULE_16
      case (REG_ADDR_IN)
        ADDR_TERM_DDC: begin
          REG_RDATA_OUT[TERM_LSB +: 2] <= transmit_termination_select;
          REG_RDATA_OUT[DDC_BIT]       <= display_channel_speed_select;
        end
        ADDR_SWING_TAP: begin
          REG_RDATA_OUT[DSWING_LSB +: 3] <= data_output_swing_select;
          REG_RDATA_OUT[CSWING_LSB +: 3] <= clock_output_swing_select;
          REG_RDATA_OUT[TAP_LSB +: 2]    <= post_cursor_tap_weight;
        end
        ADDR_EQ_GAIN: begin
          REG_RDATA_OUT                 <= RST_EQ_GAIN; // RULE_16
          REG_RDATA_OUT[DEQ_LSB +: 3]   <= data_eq_select;
          REG_RDATA_OUT[CEQ_LSB +: 2]   <= clock_eq_select;
        end
        ADDR_LOAD_SYNC: begin
          REG_RDATA_OUT[SYNC_LSB +: LANES] <= verifier_sync_pulse;
          REG_RDATA_OUT[LOAD_LSB +: LANES] <= verifier_lane_load;
        end
        ADDR_LANE_STATUS: begin
          REG_RDATA_OUT[SYNC_LSB +: LANES] <= lane_mismatch; // RULE_11
          REG_RDATA_OUT[LOAD_LSB +: LANES] <= lane_training; // RULE_12
        end
        ADDR_PAT_CFG: begin
          REG_RDATA_OUT[CP20_BIT]     <= custom_pattern_long_mode;
          REG_RDATA_OUT[LEN_LSB +: 3] <= verifier_prbs_length;
          REG_RDATA_OUT[SEL_LSB +: 3] <= verifier_pattern_select;
        end
        ADDR_CP_LOW: REG_RDATA_OUT <= custom_pattern_low;
        ADDR_CP_MID: REG_RDATA_OUT <= custom_pattern_mid;
        default:     REG_RDATA_OUT <= RST_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-lane setting holders
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    rtx_lane_if lif ();

    assign lif.load      = verifier_lane_load[g];
    assign lif.sel       = verifier_pattern_select;
    assign lif.len       = verifier_prbs_length;
    assign lif.long_mode = custom_pattern_long_mode;
    assign lif.pattern   = {CUSTOM_PATTERN_TOP_IN, custom_pattern_mid,
                            custom_pattern_low};
    assign lif.timeout   = VERIFIER_TIMEOUT_IN;

    rtx_lane_latch u_latch (
      .clk   (MCLK_IN),
      .rst_n (RESETN_IN),
      .lif   (lif)
    );

    // Held values straight from the lane flops
    assign LANE_PATTERN_MODE_OUT[g] = lif.held_mode;
    assign LANE_PRBS_LENGTH_OUT[g]  = lif.held_len;
    assign LANE_LONG_MODE_OUT[g]    = lif.held_long;
    assign LANE_PATTERN_OUT[g]      = lif.held_pattern;
    assign LANE_TIMEOUT_OUT[g]      = lif.held_timeout;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RESETN_IN);

  chk_term_strap_lock: assert property ( // RULE_01
    PIN_STRAP_MODE_IN && wr_hit(REG_WR_IN, REG_ADDR_IN, ADDR_TERM_DDC)
    |=> $stable(transmit_termination_select))
    else $error("termination written in strap mode");
  chk_tap_follows_pin: assert property ( // RULE_03
    PIN_STRAP_MODE_IN |=> post_cursor_tap_weight
      == ($past(PRE_EMPH_STRAP_IN) ? TAP_2DB : TAP_NONE))
    else $error("tap weight does not mirror the strap pin");
  chk_tap_reserved: assert property ( // RULE_02
    TAP_WEIGHT_OUT == TAP_NONE || TAP_WEIGHT_OUT == TAP_2DB)
    else $error("reserved tap weight applied");
  chk_ddc_speed_write: assert property ( // RULE_04
    wr_hit(REG_WR_IN, REG_ADDR_IN, ADDR_TERM_DDC)
    |=> DDC_FAST_MODE_OUT == $past(REG_WDATA_IN[DDC_BIT]))
    else $error("channel speed did not take the written value");
  chk_apply_gates: assert property ( // RULE_15
    !APPLY_LANE_SETTINGS_IN |=> $stable(DATA_SWING_OUT)
      && $stable(CLOCK_SWING_OUT) && $stable(DATA_EQ_OUT))
    else $error("lane settings changed without apply");
  chk_apply_takes: assert property ( // RULE_15
    APPLY_LANE_SETTINGS_IN |=> DATA_SWING_OUT
      == $past(data_output_swing_select))
    else $error("apply did not move the swing setting");
  chk_clock_eq_rsvd: assert property ( // RULE_08
    CLOCK_EQ_OUT != CEQ_RSVD)
    else $error("reserved clock equalizer code applied");
  chk_sync_set_wins: assert property ( // RULE_10
    LANE_SYNC_IN[0] |=> verifier_sync_pulse[0])
    else $error("sync pulse lost");
  chk_status_read: assert property ( // RULE_11
    REG_ADDR_IN == ADDR_LANE_STATUS ##1 REG_ADDR_IN == ADDR_LANE_STATUS
    |=> REG_RDATA_OUT == {$past(LANE_MISMATCH_IN, 2),
                          $past(LANE_TRAINING_IN, 2)})
    else $error("status read does not match lane state");
  chk_eq_reserved: assert property ( // RULE_16
    REG_ADDR_IN == ADDR_EQ_GAIN |=> REG_RDATA_OUT[0] == RST_EQ_GAIN[0]
      && REG_RDATA_OUT[7:6] == RST_ZERO[7:6])
    else $error("reserved equalizer bits read wrong");

  cov_apply_pulse:  cover property (APPLY_LANE_SETTINGS_IN);
  cov_strap_write:  cover property (PIN_STRAP_MODE_IN
    && wr_hit(REG_WR_IN, REG_ADDR_IN, ADDR_SWING_TAP));
  cov_sync_clear:   cover property (LANE_SYNC_IN[0]
    && wr_hit(REG_WR_IN, REG_ADDR_IN, ADDR_LOAD_SYNC));

endmodule

//--- design/rtx_pkg.sv
// Package: register map, field layout and codes of the retimer control bank
package rtx_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int unsigned LANES     = 4;
  localparam int unsigned TIMEOUT_W = 4;
  localparam int unsigned CP_W      = 20;
  localparam int unsigned CP_SHORT  = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] ADDR_TERM_DDC    = 8'h0B;
  localparam logic [7:0] ADDR_SWING_TAP   = 8'h0C;
  localparam logic [7:0] ADDR_EQ_GAIN     = 8'h0D;
  localparam logic [7:0] ADDR_LOAD_SYNC   = 8'h0E;
  localparam logic [7:0] ADDR_LANE_STATUS = 8'h0F;
  localparam logic [7:0] ADDR_PAT_CFG     = 8'h10;
  localparam logic [7:0] ADDR_CP_LOW      = 8'h11;
  localparam logic [7:0] ADDR_CP_MID      = 8'h12;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and constant read-back of reserved bits
  localparam logic [7:0] RST_ZERO    = 8'h00;
  localparam logic [7:0] RST_EQ_GAIN = 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned TERM_LSB   = 3;
  localparam int unsigned DDC_BIT    = 2;
  localparam int unsigned DSWING_LSB = 5;
  localparam int unsigned CSWING_LSB = 2;
  localparam int unsigned TAP_LSB    = 0;
  localparam int unsigned DEQ_LSB    = 3;
  localparam int unsigned CEQ_LSB    = 1;
  localparam int unsigned SYNC_LSB   = 4;
  localparam int unsigned LOAD_LSB   = 0;
  localparam int unsigned CP20_BIT   = 7;
  localparam int unsigned LEN_LSB    = 3;
  localparam int unsigned SEL_LSB    = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Field codes
  localparam logic [1:0] TERM_NONE   = 2'h0;
  localparam logic [1:0] TERM_150    = 2'h1;
  localparam logic [1:0] TAP_NONE    = 2'h0;
  localparam logic [1:0] TAP_2DB     = 2'h1;
  localparam logic [1:0] CEQ_0DB     = 2'h0;
  localparam logic [1:0] CEQ_RSVD    = 2'h3;
  localparam logic [2:0] SWING_DEF   = 3'h0;

  // Decoded verifier pattern mode
  typedef enum logic [2:0] {
    RTX_PAT_OFF    = 3'b000,
    RTX_PAT_PRBS   = 3'b001,
    RTX_PAT_CLOCK  = 3'b010,
    RTX_PAT_CUSTOM = 3'b011,
    RTX_PAT_TIMING = 3'b100
  } rtx_pat_mode_t;

  // Decoded PRBS polynomial order
  typedef enum logic [2:0] {
    RTX_PRBS7  = 3'b000,
    RTX_PRBS11 = 3'b001,
    RTX_PRBS23 = 3'b010,
    RTX_PRBS31 = 3'b011,
    RTX_PRBS15 = 3'b100,
    RTX_PRBS20 = 3'b101
  } rtx_prbs_t;

  // Pattern select decode, any code with the top bit set is timing only
  function automatic rtx_pat_mode_t rtx_pat_mode(input logic [2:0] sel);
    rtx_pat_mode_t m;
    m = RTX_PAT_OFF;
    case (sel)
      3'h0:    m = RTX_PAT_OFF;
      3'h1:    m = RTX_PAT_PRBS;
      3'h2:    m = RTX_PAT_CLOCK;
      3'h3:    m = RTX_PAT_CUSTOM;
      default: m = RTX_PAT_TIMING;
    endcase
    return m;
  endfunction

  // Length decode, upper codes pair up onto two orders
  function automatic rtx_prbs_t rtx_prbs_len(input logic [2:0] len);
    rtx_prbs_t p;
    p = RTX_PRBS7;
    case (len)
      3'h0:       p = RTX_PRBS7;
      3'h1:       p = RTX_PRBS11;
      3'h2:       p = RTX_PRBS23;
      3'h3:       p = RTX_PRBS31;
      3'h4, 3'h5: p = RTX_PRBS15;
      default:    p = RTX_PRBS20;
    endcase
    return p;
  endfunction

endpackage

//--- design/rtx_lane_if.sv
// Interface: verifier settings into one lane and the values it holds
interface rtx_lane_if;
  import rtx_pkg::*;
  logic                 load;
  logic [2:0]           sel;
  logic [2:0]           len;
  logic                 long_mode;
  logic [CP_W-1:0]      pattern;
  logic [TIMEOUT_W-1:0] timeout;
  rtx_pat_mode_t        held_mode;
  rtx_prbs_t            held_len;
  logic                 held_long;
  logic [CP_W-1:0]      held_pattern;
  logic [TIMEOUT_W-1:0] held_timeout;
  modport ctrl (output load, sel, len, long_mode, pattern, timeout,
                input  held_mode, held_len, held_long, held_pattern,
                       held_timeout);
  modport lane (input  load, sel, len, long_mode, pattern, timeout,
                output held_mode, held_len, held_long, held_pattern,
                       held_timeout);
endinterface

//--- design/rtx_lane_latch.sv
// Per-lane verifier settings: follow while loading, hold afterwards
module rtx_lane_latch (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Lane settings
  rtx_lane_if.lane  lif
);
  import rtx_pkg::*;

  // Follow the bank while load is high, keep the last value once it falls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lif.held_mode    <= RTX_PAT_OFF;
      lif.held_len     <= RTX_PRBS7;
      lif.held_long    <= 1'b0;
      lif.held_pattern <= '0;
      lif.held_timeout <= '0;
    end else if (lif.load) begin // RULE_09
      lif.held_mode    <= rtx_pat_mode(lif.sel); // RULE_14
      lif.held_len     <= rtx_prbs_len(lif.len); // RULE_14
      lif.held_long    <= lif.long_mode;
      lif.held_timeout <= lif.timeout;
      // Short mode keeps only the low sixteen pattern bits
      lif.held_pattern <= lif.long_mode ? lif.pattern // RULE_13
          : {{(CP_W-CP_SHORT){1'b0}}, lif.pattern[CP_SHORT-1:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_load_follows: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
    lif.load |=> lif.held_timeout == $past(lif.timeout)
              && lif.held_len == rtx_prbs_len($past(lif.len)))
    else $error("lane did not follow settings while loading");
  chk_hold_after_fall: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
    $fell(lif.load) ##1 !lif.load |-> $stable(lif.held_pattern)
                                    && $stable(lif.held_mode))
    else $error("lane settings moved after load fell");
  chk_short_pattern: assert property (@(posedge clk) disable iff (!rst_n) // RULE_13
    !lif.held_long |-> lif.held_pattern[CP_W-1:CP_SHORT] == '0)
    else $error("short custom pattern carries upper bits");
  cov_lane_load_release: cover property (@(posedge clk) disable iff (!rst_n)
    lif.load ##1 !lif.load);

endmodule

//--- testbench/rtx_host_model.sv
// Host model: register writes and registered reads
module rtx_host_model (
  // Clock
  input  wire logic       clk_in,
  // Register port
  output logic [7:0]      addr_out,
  output logic            wr_out,
  output logic [7:0]      wdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  event got;
  logic sleep_off = 1'b0;
  initial begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    wdata_out = 8'h00;
  end
  // One-cycle write; fast speed only after sleep disable is set
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    sleep_off = 1'b1;
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
  endtask
  // Read data settles one edge after the address
  task automatic rd(input logic [7:0] a);
    @(negedge clk_in);
    addr_out = a;
    @(posedge clk_in);
    @(negedge clk_in);
    ->got;
  endtask
endmodule

//--- testbench/rtx_ctrl_bank_tb.sv
// Testbench: register bank reads, strap mode, apply and lane latches
module rtx_ctrl_bank_tb;
  import rtx_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst_n = 1'b0, strap = 1'b0, pre = 1'b0, apply = 1'b0;
  logic [3:0] to = 4'h0, top = 4'h0, sync = 4'h0, mm = 4'h0, tr = 4'h0;
  logic [7:0] a, rdata, v;
  logic w;
  logic [1:0] term, tap, ceq;
  logic [2:0] dsw, csw, deq, e_len;
  logic ddc;
  logic [LANES-1:0][2:0] pmode, plen;
  logic [LANES-1:0] plong;
  logic [LANES-1:0][CP_W-1:0] pat;
  logic [LANES-1:0][TIMEOUT_W-1:0] lto;
  logic [7:0] exp_q[$];
  int n_errors = 0, samples_checked = 0, cyc = 0, l;
  logic [31:0] seed = 32'he81aabab, p;
  always #12.5 clk = ~clk;
  rtx_host_model u_host (.clk_in(clk), .addr_out(a), .wr_out(w),
    .wdata_out(v));
  rtx_ctrl_bank u_dut (.MCLK_IN(clk), .RESETN_IN(rst_n), .REG_ADDR_IN(a),
    .REG_WR_IN(w), .REG_WDATA_IN(v), .REG_RDATA_OUT(rdata),
    .PIN_STRAP_MODE_IN(strap), .PRE_EMPH_STRAP_IN(pre),
    .APPLY_LANE_SETTINGS_IN(apply), .VERIFIER_TIMEOUT_IN(to),
    .CUSTOM_PATTERN_TOP_IN(top), .LANE_SYNC_IN(sync),
    .LANE_MISMATCH_IN(mm), .LANE_TRAINING_IN(tr),
    .TX_TERMINATION_OUT(term), .TAP_WEIGHT_OUT(tap), .DATA_SWING_OUT(dsw),
    .CLOCK_SWING_OUT(csw), .DATA_EQ_OUT(deq), .CLOCK_EQ_OUT(ceq),
    .DDC_FAST_MODE_OUT(ddc), .LANE_PATTERN_MODE_OUT(pmode),
    .LANE_PRBS_LENGTH_OUT(plen), .LANE_LONG_MODE_OUT(plong),
    .LANE_PATTERN_OUT(pat), .LANE_TIMEOUT_OUT(lto));
  ////////////////////////////////////////////////////////////////////////////
  // Verdict and counts
  task automatic close_out();
    $display("compares %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [19:0] g, input logic [19:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: output %h exp %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.rd(ad);
  endtask
  task automatic pulse_apply();
    @(negedge clk);
    apply = 1'b1;
    @(negedge clk);
    apply = 1'b0;
  endtask
  // Oldest expected read value against the settled read data
  always @(u_host.got) begin
    samples_checked++;
    if (rdata !== exp_q[0]) begin
      n_errors++;
      $display("wrong value at %0t: read %h exp %h", $time, rdata, exp_q[0]);
    end
    void'(exp_q.pop_front());
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 11; i < 19; i++) rd(i[7:0], (i == 13) ? 8'h01 : 8'h00);
    u_host.wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    $display("reset values done");
    u_host.wr(8'h0B, 8'hFF);
    rd(8'h0B, 8'h1C);
    chk(ddc, 1);
    p = $random(seed);
    u_host.wr(8'h0C, p[7:0]);
    u_host.wr(8'h0D, 8'hFF);
    rd(8'h0C, p[7:0]);
    rd(8'h0D, 8'h3F);
    chk(dsw, 0);
    pulse_apply();
    chk(dsw, p[7:5]);
    chk(csw, p[4:2]);
    chk(tap, p[1] ? 2'b00 : p[1:0]);
    chk(term, 0);
    chk({deq, ceq}, 5'h1C);
    $display("apply done");
    strap = 1'b1;
    pre = 1'b1;
    u_host.wr(8'h0B, 8'h00);
    u_host.wr(8'h0C, {p[7:2], 2'b10});
    rd(8'h0B, 8'h18);
    rd(8'h0C, {p[7:2], 2'b01});
    strap = 1'b0;
    // Termination code 01 and the strapped tap reach the lanes on apply
    u_host.wr(8'h0B, 8'h08);
    pulse_apply();
    chk(term, 2'h1);
    chk(tap, 2'h1);
    chk(ddc, 0);
    p = $random(seed);
    {mm, tr, to, top} = p[15:0];
    u_host.wr(8'h0F, 8'hFF);
    rd(8'h0F, {mm, tr});
    @(negedge clk);
    sync = 4'h5;
    @(negedge clk);
    sync = 4'h0;
    rd(8'h0E, 8'h50);
    u_host.wr(8'h0E, 8'h00);
    rd(8'h0E, 8'h00);
    // Sync pulse in the same cycle as a clearing write: set wins
    fork
      u_host.wr(8'h0E, 8'h00);
      begin
        @(negedge clk);
        sync = 4'h2;
        @(negedge clk);
        sync = 4'h0;
      end
    join
    rd(8'h0E, 8'h20);
    $display("status done");
    for (int i = 0; i < 8; i++) begin
      p = $random(seed);
      l = i % 4;
      e_len = (i < 4) ? i[2:0] : ((i < 6) ? 3'd4 : 3'd5);
      u_host.wr(8'h10, {i[0], 1'b0, i[2:0], i[2:0]});
      u_host.wr(8'h11, p[7:0]);
      u_host.wr(8'h12, p[15:8]);
      u_host.wr(8'h0E, 8'h01 << l);
      u_host.wr(8'h0E, 8'h00);
      u_host.wr(8'h10, 8'h00);
      chk(pmode[l], i[2] ? 3'd4 : i[2:0]);
      chk(plen[l], e_len);
      chk(plong[l], i[0]);
      chk(pat[l], {i[0] ? top : 4'h0, p[15:0]});
      chk(lto[l], to);
    end
    $display("lane loads done");
    close_out();
  end
endmodule
